/* verilog/fscr_defines.vh */
// constants for the flash status and configuration register block
`ifndef FSCR_DEFINES_VH
`define FSCR_DEFINES_VH
// status register fields
`define FSCR_ST_BUSY        0
`define FSCR_ST_WLATCH      1
`define FSCR_ST_PROT_LO     2
`define FSCR_ST_PROT_HI     5
// configuration register fields
`define FSCR_CF_DRV_LO      0
`define FSCR_CF_DRV_HI      2
`define FSCR_CF_ORIGIN      3
`define FSCR_CF_PREAMBLE    4
// reset values
`define FSCR_PROT_RST       4'h0
`define FSCR_DRV_RST        3'h7
`define FSCR_ORIGIN_RST     1'b0
`define FSCR_PREAMBLE_RST   1'b0
// operation codes on the request port
`define FSCR_OP_WREN        3'h1
`define FSCR_OP_WRDI        3'h2
`define FSCR_OP_PROG        3'h3
`define FSCR_OP_ERASE       3'h4
`define FSCR_OP_CHIP        3'h5
`define FSCR_OP_REGWR       3'h6
// busy durations in cycles
`define FSCR_REGWR_CYC      16'h0010
`define FSCR_PROG_CYC       16'h0040
`define FSCR_ERASE_CYC      16'h0100
`define FSCR_CHIP_CYC       16'h0400
`endif

/* verilog/fscr_busy_timer.v */
// down counter that times one internal write operation
`timescale 1ns/10ps
`include "fscr_defines.vh"
module fscr_busy_timer #(
    parameter CW = 16
) (
    // clock and reset
    input  wire          mclk_i,
    input  wire          srst_i,
    // control
    input  wire          load_i,
    input  wire [CW-1:0] count_i,
    // status
    output wire          run_o,
    output wire          done_o
);
    reg [CW-1:0] cnt_ff;
    reg          done_ff;
    always @(posedge mclk_i) begin
        if (srst_i) begin
            cnt_ff  <= {CW{1'b0}};
            done_ff <= 1'b0;
        end else if (load_i) begin
            cnt_ff  <= count_i;
            done_ff <= 1'b0;
        end else if (cnt_ff != {CW{1'b0}}) begin
            cnt_ff  <= cnt_ff - {{(CW-1){1'b0}}, 1'b1};
            done_ff <= (cnt_ff == {{(CW-1){1'b0}}, 1'b1});
        end else begin
            done_ff <= 1'b0;
        end
    end
    assign run_o  = (cnt_ff != {CW{1'b0}});
    assign done_o = done_ff;
endmodule

/* verilog/fscr_regs.v */
// status and configuration registers of a serial nor flash
// Functional notes
// - busy flag in status bit 0 is high while a program, erase or register write runs, low otherwise.
// - program, erase and register write are accepted only while the write latch in status bit 1 is set.
// - program or erase aimed inside the protected region is discarded and the array is left alone.
// - status bits 5..2 are the protect level, changed only by the status register write instruction.
// - whole chip erase runs only when all four protect level bits are 0.
// - protect level bits reset to 0, so nothing is protected initially.
// - configuration settings take effect only once the register write completes.
// - configuration bits 2..0 are the drive strength code, 000 weakest, 111 strongest and default.
// - configuration bit 3 anchors the protected region at top (0, default) or bottom (1).
// - configuration bit 4 enables a preamble pattern on read dummy cycles, default off.
`timescale 1ns/10ps
`include "fscr_defines.vh"
module fscr_regs #(
    parameter AW = 16
) (
    // clock and reset
    input  wire          mclk_i,
    input  wire          srst_i,
    // operation request from the command decoder
    input  wire          op_valid_i,
    input  wire [2:0]    op_code_i,
    input  wire [AW-1:0] op_addr_i,
    input  wire [7:0]    op_status_i,
    input  wire [7:0]    op_config_i,
    // read dummy cycle indicator
    input  wire          dummy_cycle_i,
    // register read back
    output reg  [7:0]    status_o,
    output reg  [7:0]    config_o,
    // effects on the array and pads
    output reg           array_prog_o,
    output reg           array_erase_o,
    output reg           array_chip_o,
    output reg  [AW-1:0] array_addr_o,
    output reg           op_reject_o,
    output reg  [2:0]    drive_strength_o,
    output reg           preamble_drive_o
);
    // ****************************************
    // state
    // ****************************************
    reg          busy_flag_ff;
    reg          write_latch_ff;
    reg  [3:0]   protect_level_ff;
    reg  [2:0]   drive_strength_ff;
    reg          protect_origin_select_ff;
    reg          preamble_enable_ff;
    reg  [3:0]   pend_prot_ff;
    reg  [7:0]   pend_cfg_ff;
    reg          pend_regwr_ff;
    reg          nxt_load;
    reg  [15:0]  nxt_count;
    reg          nxt_accept;
    reg          nxt_reject;
    wire         tmr_run;
    wire         tmr_done;
    wire         is_write_op;
    wire         in_protected;
    wire [AW:0]  span;
    wire [AW:0]  fence;

    // ****************************************
    // protected region
    // ****************************************
    // level n (1 to 14) guards 2^n/2^(AW) of the array; level 0 guards nothing, level 15 covers everything
    assign span  = (protect_level_ff == 4'h0) ? {(AW+1){1'b0}} :
                   (protect_level_ff >= 4'hf) ? {1'b1, {AW{1'b0}}} :
                   ({{AW{1'b0}}, 1'b1} << protect_level_ff);
    assign fence = {1'b1, {AW{1'b0}}} - span;
    // top anchor guards from fence upward, bottom anchor guards below span
    assign in_protected = protect_origin_select_ff ? ({1'b0, op_addr_i} < span) :
                                                     ({1'b0, op_addr_i} >= fence);
    assign is_write_op  = (op_code_i == `FSCR_OP_PROG) || (op_code_i == `FSCR_OP_ERASE) ||
                          (op_code_i == `FSCR_OP_CHIP) || (op_code_i == `FSCR_OP_REGWR);

    // ****************************************
    // acceptance
    // ****************************************
    always @* begin
        nxt_accept = 1'b0;
        nxt_reject = 1'b0;
        nxt_load   = 1'b0;
        nxt_count  = 16'h0000;
        if (op_valid_i && is_write_op) begin
            if (busy_flag_ff || !write_latch_ff) begin
                nxt_reject = 1'b1;
            end else begin
                case (op_code_i)
                    `FSCR_OP_PROG: begin
                        nxt_reject = in_protected;
                        nxt_count  = `FSCR_PROG_CYC;
                    end
                    `FSCR_OP_ERASE: begin
                        nxt_reject = in_protected;
                        nxt_count  = `FSCR_ERASE_CYC;
                    end
                    `FSCR_OP_CHIP: begin
                        nxt_reject = (protect_level_ff != 4'h0);
                        nxt_count  = `FSCR_CHIP_CYC;
                    end
                    `FSCR_OP_REGWR: begin
                        nxt_count  = `FSCR_REGWR_CYC;
                    end
                    default: begin
                        nxt_reject = 1'b1;
                    end
                endcase
                nxt_accept = !nxt_reject;
                nxt_load   = nxt_accept;
            end
        end
    end

    fscr_busy_timer #(
        .CW      (16)
    ) u_timer (
        .mclk_i  (mclk_i),
        .srst_i  (srst_i),
        .load_i  (nxt_load),
        .count_i (nxt_count),
        .run_o   (tmr_run),
        .done_o  (tmr_done)
    );

    // ****************************************
    // flags and register contents
    // ****************************************
    always @(posedge mclk_i) begin
        if (srst_i) begin
            busy_flag_ff             <= 1'b0;
            write_latch_ff           <= 1'b0;
            protect_level_ff         <= `FSCR_PROT_RST;
            drive_strength_ff        <= `FSCR_DRV_RST;
            protect_origin_select_ff <= `FSCR_ORIGIN_RST;
            preamble_enable_ff       <= `FSCR_PREAMBLE_RST;
            pend_prot_ff             <= 4'h0;
            pend_cfg_ff              <= 8'h00;
            pend_regwr_ff            <= 1'b0;
        end else begin
            if (nxt_accept) begin
                busy_flag_ff <= 1'b1;
            end else if (busy_flag_ff && !tmr_run && !nxt_load) begin
                busy_flag_ff <= 1'b0;
            end
            if (op_valid_i && !busy_flag_ff && op_code_i == `FSCR_OP_WREN) begin
                write_latch_ff <= 1'b1;
            end else if (op_valid_i && !busy_flag_ff && op_code_i == `FSCR_OP_WRDI) begin
                write_latch_ff <= 1'b0;
            end else if (tmr_done) begin
                write_latch_ff <= 1'b0;
            end
            if (nxt_accept && op_code_i == `FSCR_OP_REGWR) begin
                pend_regwr_ff <= 1'b1;
                pend_prot_ff  <= op_status_i[`FSCR_ST_PROT_HI:`FSCR_ST_PROT_LO];
                pend_cfg_ff   <= op_config_i;
            end else if (tmr_done) begin
                pend_regwr_ff <= 1'b0;
            end
            // new values apply only when the register write completes
            if (tmr_done && pend_regwr_ff) begin
                protect_level_ff         <= pend_prot_ff;
                drive_strength_ff        <= pend_cfg_ff[`FSCR_CF_DRV_HI:`FSCR_CF_DRV_LO];
                protect_origin_select_ff <= pend_cfg_ff[`FSCR_CF_ORIGIN];
                preamble_enable_ff       <= pend_cfg_ff[`FSCR_CF_PREAMBLE];
            end
        end
    end

    // ****************************************
    // registered outputs
    // ****************************************
    always @(posedge mclk_i) begin
        if (srst_i) begin
            status_o         <= 8'h00;
            config_o         <= {3'h0, `FSCR_PREAMBLE_RST, `FSCR_ORIGIN_RST, `FSCR_DRV_RST};
            array_prog_o     <= 1'b0;
            array_erase_o    <= 1'b0;
            array_chip_o     <= 1'b0;
            array_addr_o     <= {AW{1'b0}};
            op_reject_o      <= 1'b0;
            drive_strength_o <= `FSCR_DRV_RST;
            preamble_drive_o <= 1'b0;
        end else begin
            status_o         <= {2'b00, protect_level_ff, write_latch_ff, busy_flag_ff};
            config_o         <= {3'b000, preamble_enable_ff, protect_origin_select_ff, drive_strength_ff};
            array_prog_o     <= nxt_accept && (op_code_i == `FSCR_OP_PROG);
            array_erase_o    <= nxt_accept && (op_code_i == `FSCR_OP_ERASE);
            array_chip_o     <= nxt_accept && (op_code_i == `FSCR_OP_CHIP);
            array_addr_o     <= nxt_accept ? op_addr_i : array_addr_o;
            op_reject_o      <= nxt_reject;
            drive_strength_o <= drive_strength_ff;
            preamble_drive_o <= preamble_enable_ff && dummy_cycle_i;
        end
    end
endmodule

/* tb/fscr_regs_props.sv */
// assertion checker for the flash status and configuration registers
`timescale 1ns/10ps
module fscr_regs_props (
    input wire logic       mclk_i, srst_i, op_valid_i, dummy_cycle_i,
    input wire logic [2:0] op_code_i, drive_strength_o,
    input wire logic [7:0] status_o, config_o,
    input wire logic       array_prog_o, array_erase_o, array_chip_o, op_reject_o, preamble_drive_o
);
    // cycles that busy has stood high in a row, saturating
    logic [11:0] busy_run;
    always @(posedge mclk_i) begin
        if (srst_i) busy_run <= 12'h000;
        else if (!status_o[0]) busy_run <= 12'h000;
        else if (busy_run != 12'hfff) busy_run <= busy_run + 12'h001;
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    property p_rst; $past(srst_i) |-> status_o == 8'h00 && config_o == 8'h07 && drive_strength_o == 3'h7; endproperty
    a_rst: assert property (p_rst) else $error("reset value wrong");
    property p_rej;
        op_valid_i && op_code_i >= 3'h3 && op_code_i <= 3'h6 && !status_o[1] && !$past(op_valid_i) |=> op_reject_o;
    endproperty
    a_rej: assert property (p_rej) else $error("write op without latch not refused");
    property p_rej_side; op_reject_o |-> !(array_prog_o || array_erase_o || array_chip_o); endproperty
    a_rej_side: assert property (p_rej_side) else $error("refused op reached array");
    property p_busy_prog; array_prog_o |=> status_o[0] [*8]; endproperty
    a_busy_prog: assert property (p_busy_prog) else $error("busy missing during program");
    property p_busy_end; $rose(status_o[0]) |-> status_o[0] [*8]; endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy length wrong");
    property p_busy_max; busy_run <= 12'd1100; endproperty
    a_busy_max: assert property (p_busy_max) else $error("busy never cleared");
    property p_latch_clr; $fell(status_o[0]) |-> !status_o[1]; endproperty
    a_latch_clr: assert property (p_latch_clr) else $error("latch kept after completion");
    property p_chip; array_chip_o |-> status_o[5:2] == 4'h0 && $past(op_valid_i); endproperty
    a_chip: assert property (p_chip) else $error("chip erase while protected");
    property p_cfg; $changed(config_o) |-> $fell(status_o[0]); endproperty
    a_cfg: assert property (p_cfg) else $error("config changed outside completion");
    property p_prot; $changed(status_o[5:2]) |-> $fell(status_o[0]); endproperty
    a_prot: assert property (p_prot) else $error("protect level changed outside write");
    property p_drive; $changed(config_o[2:0]) |-> ##[0:1] drive_strength_o == config_o[2:0]; endproperty
    a_drive: assert property (p_drive) else $error("drive code not applied");
    property p_pre; preamble_drive_o |-> $past(dummy_cycle_i) && config_o[4]; endproperty
    a_pre: assert property (p_pre) else $error("preamble outside dummy cycles");
endmodule
bind fscr_regs fscr_regs_props i_props (.mclk_i, .srst_i, .op_valid_i, .dummy_cycle_i, .op_code_i,
    .drive_strength_o, .status_o, .config_o, .array_prog_o, .array_erase_o, .array_chip_o, .op_reject_o,
    .preamble_drive_o);

/* tb/fscr_host.sv */
// host command decoder model issuing operations and polling status
`timescale 1ns/10ps
module fscr_host (
    input  wire logic        mclk_i,
    input  wire logic [7:0]  status_i,
    output logic             op_valid_o,
    output logic [2:0]       op_code_o,
    output logic [15:0]      op_addr_o,
    output logic [7:0]       op_status_o, op_config_o
);
    initial {op_valid_o, op_code_o, op_addr_o, op_status_o, op_config_o} = '0;
    // one-cycle request, qualifiers scrambled once released
    task automatic issue(input logic [2:0] c, input logic [15:0] a, input logic [7:0] s, f);
        @(posedge mclk_i); #2;
        {op_valid_o, op_code_o, op_addr_o, op_status_o, op_config_o} = {1'b1, c, a, s, f};
        @(posedge mclk_i); #2;
        {op_valid_o, op_code_o, op_addr_o, op_status_o, op_config_o} = {1'b0, ~c, ~a, ~s, ~f};
    endtask
    task automatic poll_idle(output logic ok);
        ok = 1'b0;
        repeat (2) @(posedge mclk_i);
        for (int n = 0; n < 3000 && !ok; n++) begin
            @(posedge mclk_i); #2;
            if (status_i[0] === 1'b0) ok = status_i[1] === 1'b0;
        end
    endtask
endmodule

/* tb/fscr_regs_tb.sv */
// self-checking bench for the flash status and configuration registers
`timescale 1ns/10ps
`include "fscr_defines.vh"
module fscr_regs_tb;
    logic        mclk_i = 0, srst_i = 1, dummy_cycle_i = 0, op_valid_i;
    logic [2:0]  op_code_i, drive_strength_o;
    logic [15:0] op_addr_i, array_addr_o;
    logic [7:0]  op_status_i, op_config_i, status_o, config_o;
    logic        array_prog_o, array_erase_o, array_chip_o, op_reject_o, preamble_drive_o;
    int          errors = 0, check_count = 0, cyc = 0;
    initial forever #12.5 mclk_i = ~mclk_i;
    fscr_regs i_dut (.mclk_i, .srst_i, .op_valid_i, .op_code_i, .op_addr_i, .op_status_i, .op_config_i,
        .dummy_cycle_i, .status_o, .config_o, .array_prog_o, .array_erase_o, .array_chip_o, .array_addr_o,
        .op_reject_o, .drive_strength_o, .preamble_drive_o);
    fscr_host i_host (.mclk_i, .status_i(status_o), .op_valid_o(op_valid_i), .op_code_o(op_code_i),
        .op_addr_o(op_addr_i), .op_status_o(op_status_i), .op_config_o(op_config_i));
    task automatic chk(input logic [15:0] got, exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #2;
    endtask
    task automatic op(input logic [2:0] c, input logic [15:0] a = 16'h0000, input logic [7:0] s = 8'h00,
                      input logic [7:0] f = 8'h07);
        i_host.issue(c, a, s, f);
    endtask
    // prog, erase, chip, reject
    task automatic pulses(input logic [3:0] e);
        chk({12'h000, array_prog_o, array_erase_o, array_chip_o, op_reject_o}, {12'h000, e});
    endtask
    task automatic wen();
        op(`FSCR_OP_WREN);
    endtask
    task automatic idle();
        logic ok;
        i_host.poll_idle(ok);
        chk({15'h0000, ok}, 16'h0001);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            report_and_stop();
        end
    end
    initial begin
        tick(5);
        srst_i = 0;
        chk(status_o, 8'h00);
        chk(config_o, 8'h07);
        chk(drive_strength_o, 3'h7);
        op(`FSCR_OP_PROG, 16'h0010);
        pulses(4'h1);
        wen();
        op(`FSCR_OP_WRDI);
        tick(2);
        chk(status_o, 8'h00);
        wen();
        op(`FSCR_OP_REGWR, 16'h0000, 8'h04, 8'h1A);
        tick(2);
        chk(status_o, 8'h03);
        chk(config_o, 8'h07);
        op(`FSCR_OP_REGWR, 16'h0000, 8'h3C, 8'h00);
        pulses(4'h1);
        idle();
        chk(status_o, 8'h04);
        chk(config_o, 8'h1A);
        chk(drive_strength_o, 3'h2);
        dummy_cycle_i = 1;
        tick(2);
        chk(preamble_drive_o, 1'b1);
        dummy_cycle_i = 0;
        tick(2);
        chk(preamble_drive_o, 1'b0);
        wen();
        op(`FSCR_OP_PROG, 16'h0001);
        pulses(4'h1);
        wen();
        op(`FSCR_OP_PROG, 16'hFFFF);
        pulses(4'h8);
        chk(array_addr_o, 16'hFFFF);
        tick(2);
        chk(status_o[0], 1'b1);
        idle();
        chk(status_o, 8'h04);
        wen();
        op(`FSCR_OP_CHIP);
        pulses(4'h1);
        wen();
        op(`FSCR_OP_REGWR, 16'h0000, 8'h00, 8'h1A);
        idle();
        chk(status_o, 8'h00);
        wen();
        op(`FSCR_OP_CHIP);
        pulses(4'h2);
        idle();
        wen();
        op(`FSCR_OP_ERASE, 16'h0001);
        pulses(4'h4);
        idle();
        report_and_stop();
    end
endmodule
